// [inc/srw_defs.svh]
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

// Clock rate in kHz, used to turn printed times into cycle counts
`define SRW_CLK_KHZ 25000
// Reset hold after the last cause clears, in milliseconds
`define SRW_RST_HOLD_MS 215
// Watchdog expiry from the last clear, in milliseconds (1.5 s)
`define SRW_WD_EXPIRY_MS 1500
// Derived cycle counts; both are whole numbers at 25 MHz
`define SRW_RST_HOLD_CYC (`SRW_RST_HOLD_MS * `SRW_CLK_KHZ)
`define SRW_WD_EXPIRY_CYC (`SRW_WD_EXPIRY_MS * `SRW_CLK_KHZ)
// Counter width, enough for the longer of the two counts
`define SRW_CNT_W 26
// Reset value of the synchroniser stages for each pin
`define SRW_PIN_RST 4'hF

`endif

// [inc/srw_pkg.sv]
package srw_pkg;

	// Pins from outside the clock domain, kept together through the synchroniser
	typedef struct packed {
		logic supply_ok;
		logic manual_reset_in_low;
		logic watchdog_strobe_in;
		logic strobe_driven;
	} srw_pins_t;

	// Reset sequencing states
	typedef enum logic [1:0] {
		SRW_ST_CAUSE = 2'b00,
		SRW_ST_HOLD = 2'b01,
		SRW_ST_RUN = 2'b10
	} srw_state_t;

endpackage

// [logic/srw_sync.sv]
`timescale 1ns/10ps
`include "srw_defs.svh"

module srw_sync
	import srw_pkg::*;
#(
	parameter int W = 4
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] stable_o
);

	logic [W-1:0] s1_r, s2_r, s3_r, stable_r;
	logic [W-1:0] stable_nxt;

	////////////////////////////////////////////////////////////////////////
	// A bit only changes once stages two and three agree; stage one is
	// read by stage two alone, so metastability never reaches the compare
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_comb begin
				stable_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : stable_r[g];
			end
		end
	endgenerate

	// Stage registers; reset to the idle level of every pin
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_r <= W'(`SRW_PIN_RST);
			s2_r <= W'(`SRW_PIN_RST);
			s3_r <= W'(`SRW_PIN_RST);
			stable_r <= W'(`SRW_PIN_RST);
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			stable_r <= stable_nxt;
		end
	end

	assign stable_o = stable_r;

endmodule

// [logic/srw_top.sv]
// Contract
// - Assert reset on low supply, manual reset low, or watchdog expiry.
// - After all causes clear, keep reset asserted a full hold period.
// - Hold period is 215 ms, applied after every cause releases.
// - Manual reset is active low, level sensitive, plus one hold period.
// - Strobe constant longer than expiry period causes one hold-period reset.
// - Watchdog expiry is 1.5 s measured from the last clear.
// - Strobe edges and asserted reset clear the watchdog; host must toggle.
// - Undriven strobe disables the watchdog; host floats it to disable.
// - Active-high output mirrors the active-low one under the same causes.
`timescale 1ns/10ps
`include "srw_defs.svh"

module srw_top
	import srw_pkg::*;
#(
	parameter int HOLD_CYC = `SRW_RST_HOLD_CYC,
	parameter int WD_CYC = `SRW_WD_EXPIRY_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic supply_ok_i,
	input wire logic manual_reset_in_low_i,
	input wire logic watchdog_strobe_in_i,
	input wire logic strobe_driven_i,
	output logic reset_out_low_active_o,
	output logic reset_out_high_active_o,
	output logic reset_od_o,
	output logic reset_od_oe_o
);

	localparam int CW = `SRW_CNT_W;
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYC - 1);
	localparam logic [CW-1:0] WD_LAST = CW'(WD_CYC - 1);

	srw_pins_t pins_raw, pins;
	srw_state_t state_r, state_nxt;
	logic [CW-1:0] hold_cnt_r, hold_cnt_nxt;
	logic [CW-1:0] wd_cnt_r, wd_cnt_nxt;
	logic strobe_prev_r, strobe_prev_nxt;
	logic rst_act_r, rst_act_nxt;
	logic level_cause, strobe_edge, wd_expire;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_comb begin
		pins_raw.supply_ok = supply_ok_i;
		pins_raw.manual_reset_in_low = manual_reset_in_low_i;
		pins_raw.watchdog_strobe_in = watchdog_strobe_in_i;
		pins_raw.strobe_driven = strobe_driven_i;
	end

	srw_sync #(
		.W($bits(srw_pins_t))
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(pins_raw),
		.stable_o(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// Cause decode
	// cause terms
	assign level_cause = !pins.supply_ok || !pins.manual_reset_in_low;
	assign strobe_edge = pins.watchdog_strobe_in != strobe_prev_r;
	// expiry only when running, driven and no edge this cycle
	assign wd_expire = (state_r == SRW_ST_RUN) && pins.strobe_driven && !strobe_edge
		&& (wd_cnt_r == WD_LAST);

	////////////////////////////////////////////////////////////////////////
	// Reset sequencer: a cause sends us to CAUSE; HOLD only ends after the
	// full count, so a cause that returns mid-hold restarts the whole period
	always_comb begin
		state_nxt = state_r;
		hold_cnt_nxt = hold_cnt_r;
		unique case (state_r)
			SRW_ST_RUN: begin
				if (level_cause || wd_expire) begin
					state_nxt = SRW_ST_CAUSE;
				end
			end
			SRW_ST_CAUSE: begin
				// stay while supply is low or manual reset is held low
				if (!level_cause) begin
					state_nxt = SRW_ST_HOLD;
				end
				hold_cnt_nxt = '0;
			end
			SRW_ST_HOLD: begin
				if (level_cause) begin
					state_nxt = SRW_ST_CAUSE;
					hold_cnt_nxt = '0;
				end else if (hold_cnt_r == HOLD_LAST) begin
					state_nxt = SRW_ST_RUN;
					hold_cnt_nxt = '0;
				end else begin
					hold_cnt_nxt = hold_cnt_r + 1'b1;
				end
			end
			default: begin
				state_nxt = SRW_ST_CAUSE;
				hold_cnt_nxt = '0;
			end
		endcase
		// one internal level feeds every output polarity
		rst_act_nxt = state_nxt != SRW_ST_RUN;
	end

	// Sequencer registers; reset comes up asserted
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= SRW_ST_CAUSE;
			hold_cnt_r <= '0;
			rst_act_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			rst_act_r <= rst_act_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter; a floating strobe pin would toggle at random, so
	// the counter is held at zero rather than trusting the level
	always_comb begin
		strobe_prev_nxt = pins.watchdog_strobe_in;
		// held clear during reset
		// Also cleared on the edge that asserts reset, so no count leaks into it
		if (state_r != SRW_ST_RUN || state_nxt != SRW_ST_RUN) begin
			wd_cnt_nxt = '0;
		end else if (!pins.strobe_driven) begin
			wd_cnt_nxt = '0;
		end else if (strobe_edge || wd_expire) begin
			wd_cnt_nxt = '0;
		end else begin
			wd_cnt_nxt = wd_cnt_r + 1'b1;
		end
	end

	// Watchdog registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_cnt_r <= '0;
			strobe_prev_r <= 1'b1;
		end else begin
			wd_cnt_r <= wd_cnt_nxt;
			strobe_prev_r <= strobe_prev_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pins, all straight from flops
	logic out_low_r, out_high_r, od_oe_r;

	// mirrored polarities; open-drain only pulls low
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_low_r <= 1'b0;
			out_high_r <= 1'b1;
			od_oe_r <= 1'b1;
		end else begin
			out_low_r <= !rst_act_nxt;
			out_high_r <= rst_act_nxt;
			od_oe_r <= rst_act_nxt;
		end
	end

	// Open-drain data is a constant low flop, enable carries the reset
	logic od_data_r;
	always_ff @(posedge clk_i) begin
		od_data_r <= 1'b0;
	end

	assign reset_out_low_active_o = out_low_r;
	assign reset_out_high_active_o = out_high_r;
	assign reset_od_o = od_data_r;
	assign reset_od_oe_o = od_oe_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence cause_gone_s;
		(state_r == SRW_ST_CAUSE) && !level_cause;
	endsequence

	sequence hold_start_s;
		(state_r == SRW_ST_HOLD) && (hold_cnt_r == '0);
	endsequence

	cause_asserts_a: assert property (
		(level_cause || wd_expire) |=> out_high_r && !out_low_r)
		else $error("reset not asserted on a cause");

	hold_full_a: assert property (
		$fell(out_high_r) |-> $past(hold_cnt_r) == HOLD_LAST && $past(!level_cause))
		else $error("reset released before the full hold");

	hold_start_a: assert property (
		cause_gone_s |=> hold_start_s ##1 (hold_cnt_r == 1 || state_r == SRW_ST_CAUSE))
		else $error("hold count did not start from zero");

	manual_level_a: assert property (
		!pins.manual_reset_in_low [*2] |-> out_high_r && state_r == SRW_ST_CAUSE)
		else $error("reset dropped while manual reset low");

	wd_expire_a: assert property (
		wd_expire |=> state_r == SRW_ST_CAUSE ##1 state_r != SRW_ST_RUN)
		else $error("expiry did not start a reset");

	wd_bound_a: assert property (
		state_r == SRW_ST_RUN |-> wd_cnt_r <= WD_LAST)
		else $error("watchdog counted past its expiry");

	wd_clear_a: assert property (
		strobe_edge |=> wd_cnt_r == '0)
		else $error("strobe edge did not clear the watchdog");

	wd_off_a: assert property (
		!pins.strobe_driven |-> !wd_expire ##1 wd_cnt_r == '0)
		else $error("watchdog active with strobe undriven");

	pol_mirror_a: assert property (
		out_high_r == !out_low_r && od_oe_r == out_high_r && !od_data_r
		&& rst_act_r == out_high_r)
		else $error("output polarities disagree");

	wd_held_a: assert property (
		out_high_r |-> wd_cnt_r == '0)
		else $error("watchdog counted during reset");

endmodule

// [test/srw_host_model.sv]
`timescale 1ns/10ps
module srw_host_model (
	input wire logic clk_i,
	input wire logic [1:0] mode_i,
	input wire logic [7:0] period_i,
	output logic strobe_o,
	output logic driven_o
);
	int cnt = 0;
	logic lvl_r = 1'b1;
	// Mode 0 toggles the strobe, 1 stalls it, 2 floats the pin
	always @(posedge clk_i) begin
		cnt <= #1 (cnt + 1 >= period_i) ? 0 : cnt + 1;
		if (mode_i == 2'h0 && cnt + 1 >= period_i) begin
			lvl_r <= #1 ~lvl_r;
		end
	end
	// pin left floating
	// A floated pin shows the inverse level, so a stale value cannot pass
	assign strobe_o = (mode_i == 2'h2) ? ~lvl_r : lvl_r;
	assign driven_o = (mode_i != 2'h2);
endmodule

// [test/test_srw_top.sv]
`timescale 1ns/10ps
module test_srw_top;
	import srw_pkg::*;
	localparam int HOLD = 20;
	localparam int WD = 50;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic mr_low = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [7:0] period = 8'h0A;
	logic strobe, driven, rst_low, rst_h, od, od_oe;
	logic prev_s = 1'b1;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int last_edge = 0;
	int n;

	srw_top #(.HOLD_CYC(HOLD), .WD_CYC(WD)) u_srw_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.supply_ok_i(supply_ok_i), .manual_reset_in_low_i(mr_low),
		.watchdog_strobe_in_i(strobe), .strobe_driven_i(driven),
		.reset_out_low_active_o(rst_low), .reset_out_high_active_o(rst_h),
		.reset_od_o(od), .reset_od_oe_o(od_oe));
	srw_host_model u_srw_host_model (.clk_i(clk_i), .mode_i(mode), .period_i(period),
		.strobe_o(strobe), .driven_o(driven));

	always #20 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	// Cycle count and cycle of the last strobe change, reference for expiry
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		prev_s <= strobe;
		if (strobe !== prev_s) last_edge <= cyc;
	end

	// All output variants must show the same reset at every cycle
	always @(negedge clk_i) begin
		n_tests++;
		if ({rst_h, od_oe, od} !== {~rst_low, ~rst_low, 1'b0}) begin
			err_total++;
			$display("[ERR] variants expected %b seen %b", {~rst_low, ~rst_low, 1'b0}, {rst_h, od_oe, od});
		end
	end

	task automatic chk(input string nm, input int lo, input int hi, input int got);
		n_tests++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	// Bounded wait for the low-active output to reach a level, in cycles
	task automatic wait_lvl(input logic v, input int lim, output int k);
		k = 0;
		while (rst_low !== v && k < lim) begin
			@(posedge clk_i);
			#1;
			k++;
		end
	endtask

	// Applies one cause and times the assert, holds it len more cycles, then times the release
	task automatic cause(input int which, input int len, input int lo, input int hi);
		int k;
		if (which == 0) supply_ok_i = 1'b0;
		else mr_low = 1'b0;
		wait_lvl(1'b0, 10, k);
		chk("assert delay", lo, hi, k);
		repeat (len) @(posedge clk_i);
		#1;
		chk("held while low", 1, 1, int'(rst_low === 1'b0));
		if (which == 0) supply_ok_i = 1'b1;
		else mr_low = 1'b1;
		wait_lvl(1'b1, HOLD + 20, k);
		chk("hold time", HOLD + 3, HOLD + 6, k);
	endtask

	task automatic end_of_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; manual reset rests high as an unused input would
	initial begin
		n = $urandom(32'hB4F0);
		repeat (16) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		chk("reset level", 1, 1, int'(rst_low === 1'b0));
		wait_lvl(1'b1, HOLD + 20, n);
		chk("start hold", HOLD, HOLD + 6, n);
		for (int i = 0; i < 6; i++) begin
			cause(i % 2, 2 + $urandom % 30, 3, 6);
		end
		supply_ok_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1 supply_ok_i = 1'b1;
		repeat (HOLD / 2) @(posedge clk_i);
		#1 cause(0, 8, 0, 0);
		repeat (3 * WD) @(posedge clk_i);
		#1 chk("no expiry", 1, 1, int'(rst_low === 1'b1));
		mode = 2'h1;
		wait_lvl(1'b0, WD + 40, n);
		chk("expiry time", WD + 2, WD + 7, cyc - last_edge);
		wait_lvl(1'b1, HOLD + 20, n);
		chk("wd reset len", HOLD + 1, HOLD + 3, n);
		wait_lvl(1'b0, WD + 20, n);
		chk("fresh count", WD, WD + 2, n);
		mode = 2'h2;
		wait_lvl(1'b1, HOLD + 20, n);
		repeat (4 * WD) @(posedge clk_i);
		#1 chk("floated strobe", 1, 1, int'(rst_low === 1'b1));
		end_of_test();
	end

	// A hang counts as a mismatch and ends the run the usual way
	initial begin
		#(40 * 20000);
		err_total++;
		end_of_test();
	end
endmodule
